// File: cpk_pkg.sv
/*
 Constants, register map and types for the coprocessor kill and status port.
 Assumes a single core clock of 250 MHz shared with the coprocessor.
*/
package cpk_pkg;
	// Core clock period in nanoseconds.
	localparam int unsigned CPK_CLK_PERIOD_NS = 4;
	// Least time the coprocessor reset output stands, in nanoseconds.
	localparam int unsigned CPK_RESET_HOLD_NS = 16;
	// Least hold rounded up to whole clock cycles.
	localparam int unsigned CPK_RESET_HOLD_CYC =
		(CPK_RESET_HOLD_NS + CPK_CLK_PERIOD_NS - 1) / CPK_CLK_PERIOD_NS;
	// Width of the hold counter.
	localparam int unsigned CPK_HOLD_W = 3;
	localparam logic [CPK_HOLD_W-1:0] CPK_HOLD_LOAD =
		CPK_HOLD_W'(CPK_RESET_HOLD_CYC);
	localparam logic [CPK_HOLD_W-1:0] CPK_HOLD_ZERO = 3'h0;
	// Instruction tags in flight.
	localparam int unsigned CPK_TAG_W = 2;
	localparam int unsigned CPK_TAGS = 4;
	// Kill type encodings.
	localparam logic [1:0] CPK_KILL_COMMIT = 2'h0;
	localparam logic [1:0] CPK_KILL_COMMIT_ALT = 2'h1;
	localparam logic [1:0] CPK_KILL_OTHER = 2'h2;
	localparam logic [1:0] CPK_KILL_EXC = 2'h3;
	// Bit of the kill type that says killed.
	localparam int unsigned CPK_KILL_BIT = 1;
	// Register byte addresses.
	localparam logic [7:0] CPK_REG_CTRL = 8'h00;
	localparam logic [7:0] CPK_REG_STATUS = 8'h04;
	localparam logic [7:0] CPK_REG_KILLCNT = 8'h08;
	// Control fields.
	localparam int unsigned CPK_CTRL_SOFT_RST = 0;
	localparam int unsigned CPK_CTRL_SLEEP_EN = 1;
	localparam logic CPK_SLEEP_EN_RESET = 1'h1;
	// Status fields.
	localparam int unsigned CPK_STAT_STRAP = 0;
	localparam int unsigned CPK_STAT_QUIET = 1;
	localparam int unsigned CPK_STAT_SLEEP = 2;
	localparam int unsigned CPK_STAT_RESET = 3;
	// Kill counter width.
	localparam int unsigned CPK_CNT_W = 16;
	// Sleep controller states.
	typedef enum logic [1:0] {CPK_RUN, CPK_DRAIN, CPK_SLEEP} cpk_pwr_state_type;
endpackage

// File: cpk_ctl_if.sv
/*
 Internal carrier between the port top and its two helper modules.
 Assumes all users sit on the core clock.
*/
`timescale 1ns/100ps
interface cpk_ctl_if;
	// Kill request from the pipeline and its encoding.
	logic kill_squash;
	logic kill_exc_in;
	logic [1:0] kill_type;
	// Sleep and reset control.
	logic sleep_req;
	logic sleep_en;
	logic strap;
	logic quiescent;
	logic reset_req;
	logic sleep_active;
	logic reset_hold;
	// Encoder side.
	modport enc (input kill_squash, input kill_exc_in, output kill_type);
	// Power controller side.
	modport pwr (input sleep_req, input sleep_en, input strap,
		input quiescent, input reset_req, output sleep_active,
		output reset_hold);
	// Top side.
	modport top (output kill_squash, output kill_exc_in, input kill_type,
		output sleep_req, output sleep_en, output strap, output quiescent,
		output reset_req, input sleep_active, input reset_hold);
endinterface

// File: cpk_kill_enc.sv
/*
 Encodes a pipeline kill decision into the two-bit kill type.
 Assumes the top registers the result before it reaches a pin.
*/
`timescale 1ns/100ps
module cpk_kill_enc
(
	// Carrier.
	cpk_ctl_if.enc ctl
);
	// Pure decode; there is no state to hold.
	always_comb
	begin
		if (!ctl.kill_squash)
		begin
			// Commit; the alternate commit code is never produced.
			ctl.kill_type = cpk_pkg::CPK_KILL_COMMIT;
		end
		else if (ctl.kill_exc_in)
		begin
			// Killed because the coprocessor raised an exception.
			ctl.kill_type = cpk_pkg::CPK_KILL_EXC;
		end
		else
		begin
			// Killed for any other reason.
			ctl.kill_type = cpk_pkg::CPK_KILL_OTHER;
		end
	end
endmodule

// File: cpk_pwr_ctl.sv
/*
 Sleep gating and coprocessor reset stretching.
 Assumes synchronous active-low reset on the core clock.
*/
`timescale 1ns/100ps
module cpk_pwr_ctl
(
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// Carrier.
	cpk_ctl_if.pwr ctl
);
	// All state of the controller.
	typedef struct packed {
		cpk_pkg::cpk_pwr_state_type state;
		logic [cpk_pkg::CPK_HOLD_W-1:0] hold;
	} cpk_pwr_type;

	cpk_pwr_type st_reg;
	cpk_pwr_type st_next;
	logic ok_sleep;

	assign ok_sleep = !ctl.strap || ctl.quiescent;
	assign ctl.sleep_active = (st_reg.state == cpk_pkg::CPK_SLEEP);
	assign ctl.reset_hold = (st_reg.hold != cpk_pkg::CPK_HOLD_ZERO);

	// Next state; a reset request also forces the core awake.
	always_comb
	begin
		st_next = st_reg;
		if (st_reg.hold != cpk_pkg::CPK_HOLD_ZERO)
		begin
			st_next.hold = st_reg.hold - 3'h1;
		end
		if (ctl.reset_req)
		begin
			st_next.hold = cpk_pkg::CPK_HOLD_LOAD;
			st_next.state = cpk_pkg::CPK_RUN;
		end
		else
		begin
			case (st_reg.state)
				cpk_pkg::CPK_RUN:
				begin
					// Wait request seen, begin draining.
					if (ctl.sleep_req && ctl.sleep_en)
					begin
						st_next.state = cpk_pkg::CPK_DRAIN;
					end
				end
				cpk_pkg::CPK_DRAIN:
				begin
					if (!ctl.sleep_req)
					begin
						st_next.state = cpk_pkg::CPK_RUN;
					end
					else if (ok_sleep)
					begin
						st_next.state = cpk_pkg::CPK_SLEEP;
					end
				end
				cpk_pkg::CPK_SLEEP:
				begin
					// Wake when asked or when the coprocessor stirs.
					if (!ctl.sleep_req || !ok_sleep)
					begin
						st_next.state = cpk_pkg::CPK_RUN;
					end
				end
				default:
				begin
					st_next.state = cpk_pkg::CPK_RUN;
				end
			endcase
		end
	end

	// State register; reset loads a full hold so the output starts high.
	always_ff @(posedge i_core_clk)
	begin
		if (!i_resetn)
		begin
			st_reg.state <= cpk_pkg::CPK_RUN;
			st_reg.hold <= cpk_pkg::CPK_HOLD_LOAD;
		end
		else
		begin
			st_reg <= st_next;
		end
	end
endmodule

// File: cpk_port.sv
/*
 Core side of the coprocessor kill and status port: kill signalling,
 killed-instruction transaction blocking, coprocessor reset, present
 strap capture, idle-gated sleep and a small register port.
 Assumes the coprocessor shares the core clock and that all inputs are
 synchronous to it.
*/
`timescale 1ns/100ps

// Notes on behaviour
// - kill type 0x commit, 10 other, 11 exception
// - no transactions for a killed instruction
// - coprocessor reset on hard or soft reset
// - sleep only when coprocessor idle or strapped absent
// - kill strobe marks the valid kill type
module cpk_port
(
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// Integer unit reset and wait requests.
	input wire logic i_soft_reset,
	input wire logic i_sleep_req,
	// Kill decision from the pipeline.
	input wire logic i_kill_valid,
	input wire logic i_kill_squash,
	input wire logic [cpk_pkg::CPK_TAG_W-1:0] i_kill_tag,
	input wire logic i_coproc_exception_flag,
	// New instruction issued to the coprocessor.
	input wire logic i_issue_valid,
	input wire logic [cpk_pkg::CPK_TAG_W-1:0] i_issue_tag,
	// Later core-side transaction for an instruction.
	input wire logic i_xact_valid,
	input wire logic [cpk_pkg::CPK_TAG_W-1:0] i_xact_tag,
	// Transaction offered by the coprocessor.
	input wire logic i_cop_xact_valid,
	input wire logic [cpk_pkg::CPK_TAG_W-1:0] i_cop_xact_tag,
	// Coprocessor status.
	input wire logic i_coproc_attached_strap,
	input wire logic i_coproc_quiescent,
	// Register port.
	input wire logic [7:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	// Kill signalling to the coprocessor.
	output logic o_kill_strobe,
	output logic [1:0] o_kill_type,
	// Filtered transactions.
	output logic o_xact_issue,
	output logic [cpk_pkg::CPK_TAG_W-1:0] o_xact_tag,
	output logic o_cop_xact_accept,
	// Reset and power.
	output logic o_coproc_reset_out,
	output logic o_sleep_active,
	// Register read data.
	output logic [31:0] o_reg_rdata
);
	// All state of the port top in one record; the sleep and reset controller keeps its own.
	typedef struct packed {
		logic kill_strobe;
		logic [1:0] kill_type;
		logic [cpk_pkg::CPK_TAGS-1:0] killed;
		logic xact_issue;
		logic [cpk_pkg::CPK_TAG_W-1:0] xact_tag;
		logic cop_accept;
		logic [31:0] rdata;
		logic sleep_en;
		logic soft_rst;
		logic strap_done;
		logic strap;
		logic [cpk_pkg::CPK_CNT_W-1:0] kill_cnt;
		logic coproc_reset;
		logic sleep;
	} cpk_top_state_type;

	// Registered state and its next value.
	cpk_top_state_type st_reg;
	cpk_top_state_type st_next;
	// Per-tag next value of the killed flags.
	logic [cpk_pkg::CPK_TAGS-1:0] killed_next;
	// Kill of the current cycle that retires its tag.
	logic kill_now;
	// Status word assembled for reads.
	logic [31:0] status_word;

	// Carrier to the helpers.
	cpk_ctl_if ctl ();

	// Kill type encoder.
	cpk_kill_enc u_enc
	(
		.ctl (ctl.enc)
	);

	// Sleep and reset controller.
	cpk_pwr_ctl u_pwr
	(
		.i_core_clk (i_core_clk),
		.i_resetn (i_resetn),
		.ctl (ctl.pwr)
	);

	// Drive the carrier.
	assign ctl.kill_squash = i_kill_squash;
	assign ctl.kill_exc_in = i_coproc_exception_flag;
	assign ctl.sleep_req = i_sleep_req;
	assign ctl.sleep_en = st_reg.sleep_en;
	assign ctl.strap = st_reg.strap;
	assign ctl.quiescent = i_coproc_quiescent;
	// soft reset from pipeline or software
	assign ctl.reset_req = i_soft_reset || st_reg.soft_rst;

	// A kill with the killed bit set retires its tag now.
	assign kill_now = i_kill_valid && ctl.kill_type[cpk_pkg::CPK_KILL_BIT];

	// Killed flags, one per tag; a kill beats a reissue of the same tag so
	// that no stale instruction slips a transaction past the kill.
	genvar g;
	generate
		for (g = 0; g < cpk_pkg::CPK_TAGS; g = g + 1)
		begin : g_tag
			always_comb
			begin
				if (kill_now && (i_kill_tag == cpk_pkg::CPK_TAG_W'(g)))
				begin
					killed_next[g] = 1'b1;
				end
				else if (i_issue_valid &&
					(i_issue_tag == cpk_pkg::CPK_TAG_W'(g)))
				begin
					killed_next[g] = 1'b0;
				end
				else
				begin
					killed_next[g] = st_reg.killed[g];
				end
			end
		end
	endgenerate

	// Status word; unused bits read as zero.
	always_comb
	begin
		status_word = 32'h0;
		status_word[cpk_pkg::CPK_STAT_STRAP] = st_reg.strap;
		status_word[cpk_pkg::CPK_STAT_QUIET] =
			st_reg.strap && i_coproc_quiescent;
		status_word[cpk_pkg::CPK_STAT_SLEEP] = st_reg.sleep;
		status_word[cpk_pkg::CPK_STAT_RESET] = st_reg.coproc_reset;
	end

	// Next-state logic for the whole port.
	always_comb
	begin
		st_next = st_reg;

		st_next.kill_strobe = i_kill_valid;
		// The type only means something while the strobe is high, so it
		// is held at commit otherwise to keep the pins quiet.
		if (i_kill_valid)
		begin
			st_next.kill_type = ctl.kill_type;
		end
		else
		begin
			st_next.kill_type = cpk_pkg::CPK_KILL_COMMIT;
		end

		// Killed flags; a coprocessor reset flushes every tag anyway.
		if (ctl.reset_hold)
		begin
			st_next.killed = '0;
		end
		else
		begin
			st_next.killed = killed_next;
		end

		st_next.xact_issue = i_xact_valid && !killed_next[i_xact_tag];
		st_next.xact_tag = i_xact_tag;
		st_next.cop_accept = i_cop_xact_valid &&
			!killed_next[i_cop_xact_tag];

		// Count killed instructions; the count saturates.
		if (kill_now && (st_reg.kill_cnt != '1))
		begin
			st_next.kill_cnt = st_reg.kill_cnt + 16'h1;
		end

		// Strap is caught once, in the first cycle after reset release.
		if (!st_reg.strap_done)
		begin
			st_next.strap = i_coproc_attached_strap;
			st_next.strap_done = 1'b1;
		end

		// The soft reset bit is a one-cycle pulse from software.
		st_next.soft_rst = 1'b0;

		// Register writes.
		if (i_reg_wr)
		begin
			case (i_reg_addr)
				cpk_pkg::CPK_REG_CTRL:
				begin
					st_next.soft_rst =
						i_reg_wdata[cpk_pkg::CPK_CTRL_SOFT_RST];
					st_next.sleep_en =
						i_reg_wdata[cpk_pkg::CPK_CTRL_SLEEP_EN];
				end
				cpk_pkg::CPK_REG_KILLCNT:
				begin
					// Any write clears, but a kill this cycle still counts.
					st_next.kill_cnt = kill_now ? 16'h1 : 16'h0;
				end
				default:
				begin
					// Writes elsewhere are ignored.
					st_next.sleep_en = st_reg.sleep_en;
				end
			endcase
		end

		// Register reads answer one cycle later; unmapped reads give zero.
		st_next.rdata = 32'h0;
		if (i_reg_rd)
		begin
			case (i_reg_addr)
				cpk_pkg::CPK_REG_CTRL:
				begin
					st_next.rdata[cpk_pkg::CPK_CTRL_SLEEP_EN] =
						st_reg.sleep_en;
				end
				cpk_pkg::CPK_REG_STATUS:
				begin
					st_next.rdata = status_word;
				end
				cpk_pkg::CPK_REG_KILLCNT:
				begin
					st_next.rdata[cpk_pkg::CPK_CNT_W-1:0] = st_reg.kill_cnt;
				end
				default:
				begin
					st_next.rdata = 32'h0;
				end
			endcase
		end

		st_next.coproc_reset = ctl.reset_hold || ctl.reset_req;
		st_next.sleep = ctl.sleep_active;
	end

	// State register; hard reset forces the coprocessor reset high.
	always_ff @(posedge i_core_clk)
	begin
		if (!i_resetn)
		begin
			st_reg.kill_strobe <= 1'b0;
			st_reg.kill_type <= cpk_pkg::CPK_KILL_COMMIT;
			st_reg.killed <= '0;
			st_reg.xact_issue <= 1'b0;
			st_reg.xact_tag <= '0;
			st_reg.cop_accept <= 1'b0;
			st_reg.rdata <= 32'h0;
			st_reg.sleep_en <= cpk_pkg::CPK_SLEEP_EN_RESET;
			st_reg.soft_rst <= 1'b0;
			st_reg.strap_done <= 1'b0;
			st_reg.strap <= 1'b0;
			st_reg.kill_cnt <= '0;
			st_reg.coproc_reset <= 1'b1;
			st_reg.sleep <= 1'b0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state record.
	assign o_kill_strobe = st_reg.kill_strobe;
	assign o_kill_type = st_reg.kill_type;
	assign o_xact_issue = st_reg.xact_issue;
	assign o_xact_tag = st_reg.xact_tag;
	assign o_cop_xact_accept = st_reg.cop_accept;
	assign o_coproc_reset_out = st_reg.coproc_reset;
	assign o_sleep_active = st_reg.sleep;
	assign o_reg_rdata = st_reg.rdata;
endmodule

// File: cpk_port_monitor.sv
/*
 Checker for the kill, reset and sleep outputs of the port top.
 Assumes it is bound to cpk_port and sees only its ports.
*/
`timescale 1ns/100ps
module cpk_port_monitor
(
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// Watched requests.
	input wire logic i_soft_reset,
	input wire logic i_kill_valid,
	input wire logic i_kill_squash,
	input wire logic [cpk_pkg::CPK_TAG_W-1:0] i_kill_tag,
	input wire logic i_coproc_exception_flag,
	input wire logic i_xact_valid,
	input wire logic [cpk_pkg::CPK_TAG_W-1:0] i_xact_tag,
	input wire logic i_coproc_attached_strap,
	input wire logic i_coproc_quiescent,
	// Watched outputs.
	input wire logic o_kill_strobe,
	input wire logic [1:0] o_kill_type,
	input wire logic o_xact_issue,
	input wire logic o_coproc_reset_out,
	input wire logic o_sleep_active
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_resetn);
	// A kill decision that really kills.
	sequence s_kill;
		i_kill_valid && i_kill_squash;
	endsequence
	// A fitted coprocessor that is still working.
	sequence s_busy;
		i_coproc_attached_strap && !i_coproc_quiescent;
	endsequence
	a_strobe_follows: assert property (
		i_kill_valid |=> o_kill_strobe) else $error("kill strobe missing");
	a_strobe_cause: assert property (
		o_kill_strobe |-> $past(i_kill_valid)) else $error("stray strobe");
	a_type_exc: assert property (
		s_kill ##0 i_coproc_exception_flag |=> o_kill_type == 2'h3)
		else $error("exception kill type wrong");
	a_type_other: assert property (
		s_kill ##0 !i_coproc_exception_flag |=> o_kill_type == 2'h2)
		else $error("plain kill type wrong");
	a_type_commit: assert property (
		i_kill_valid && !i_kill_squash |=> !o_kill_type[1])
		else $error("commit shown as kill");
	a_killed_blocked: assert property (
		s_kill ##0 (i_xact_valid && i_xact_tag == i_kill_tag)
		|=> !o_xact_issue) else $error("killed tag passed");
	a_soft_reset: assert property (
		i_soft_reset |=> o_coproc_reset_out) else $error("no soft reset out");
	a_hard_reset: assert property (
		$rose(i_resetn) |-> o_coproc_reset_out) else $error("no hard reset out");
	// The wake path takes two edges, so three busy samples would do; four leave one of margin.
	a_sleep_gate: assert property (
		s_busy [*4] |-> !o_sleep_active) else $error("slept while busy");
endmodule

// File: cpk_cop_model.sv
/*
 Behavioural model of the attached coprocessor.
 Assumes the core clock and the port's kill and reset outputs.
*/
`timescale 1ns/100ps
module cpk_cop_model
(
	// Clock and core side.
	input wire logic i_core_clk,
	input wire logic i_kill_strobe,
	input wire logic [1:0] i_kill_type,
	input wire logic i_coproc_reset_out,
	// Commands from the bench.
	input wire logic i_start,
	input wire logic [cpk_pkg::CPK_TAG_W-1:0] i_tag,
	input wire logic i_offer,
	input wire logic i_rogue,
	// Outputs to the core.
	output logic o_coproc_quiescent,
	output logic o_cop_xact_valid = 1'b0,
	output logic [cpk_pkg::CPK_TAG_W-1:0] o_cop_xact_tag = 2'h0
);
	logic [3:0] busy_cnt = 4'h0; // Cycles of work left.
	logic killed = 1'b0; // Current instruction was killed.
	logic [cpk_pkg::CPK_TAG_W-1:0] cur_tag = 2'h0; // Current tag.
	// idle only when no work left
	assign o_coproc_quiescent = (busy_cnt == 4'h0);
	// One process keeps work, kill and offer state.
	always @(posedge i_core_clk)
	begin
		o_cop_xact_valid <= 1'b0;
		// Released tag lines toggle so a stale value never looks valid.
		o_cop_xact_tag <= ~o_cop_xact_tag;
		// reset drops all work in flight
		if (i_coproc_reset_out)
		begin
			busy_cnt <= 4'h0;
			killed <= 1'b0;
		end
		else
		begin
			if (i_start)
			begin
				busy_cnt <= 4'hF;
				killed <= 1'b0;
				cur_tag <= i_tag;
			end
			else if (busy_cnt != 4'h0)
				busy_cnt <= busy_cnt - 4'h1;
			if (i_kill_strobe && i_kill_type[1])
				killed <= 1'b1;
			// no offer for a killed instruction unless i_rogue is set
			if (i_offer && (!killed || i_rogue))
			begin
				o_cop_xact_valid <= 1'b1;
				o_cop_xact_tag <= cur_tag;
			end
		end
	end
endmodule

// File: cpk_port_tb.sv
/*
 Self-checking bench for the coprocessor kill and status port.
 Assumes the coprocessor model and the checker are compiled first.
*/
`timescale 1ns/100ps
module cpk_port_tb;
	logic i_core_clk = 1'b0, i_resetn = 1'b0, i_soft_reset = 1'b0;
	logic i_sleep_req = 1'b0, i_kill_valid = 1'b0, i_kill_squash = 1'b0;
	logic i_coproc_exception_flag = 1'b0, i_issue_valid = 1'b0;
	logic i_xact_valid = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
	logic [1:0] i_kill_tag = 2'h0, i_issue_tag = 2'h0, i_xact_tag = 2'h0;
	logic [1:0] i_cop_xact_tag, o_kill_type, o_xact_tag, m_tag = 2'h0;
	logic [7:0] i_reg_addr = 8'h00;
	logic [31:0] i_reg_wdata = 32'h0, o_reg_rdata, rv;
	logic i_coproc_attached_strap = 1'b1; // coprocessor fitted
	logic i_cop_xact_valid, i_coproc_quiescent, o_kill_strobe, o_xact_issue;
	logic o_cop_xact_accept, o_coproc_reset_out, o_sleep_active;
	logic m_start = 1'b0, m_offer = 1'b0, m_rogue = 1'b0, sq, ex;
	int failures = 0, checked = 0, seed = 32'hf969837d, nk = 0;
	cpk_port DUT (.i_core_clk, .i_resetn, .i_soft_reset, .i_sleep_req,
		.i_kill_valid, .i_kill_squash, .i_kill_tag, .i_coproc_exception_flag,
		.i_issue_valid, .i_issue_tag, .i_xact_valid, .i_xact_tag,
		.i_cop_xact_valid, .i_cop_xact_tag, .i_coproc_attached_strap,
		.i_coproc_quiescent, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
		.o_kill_strobe, .o_kill_type, .o_xact_issue, .o_xact_tag,
		.o_cop_xact_accept, .o_coproc_reset_out, .o_sleep_active, .o_reg_rdata);
	cpk_cop_model u_cop (.i_core_clk, .i_kill_strobe(o_kill_strobe),
		.i_kill_type(o_kill_type), .i_coproc_reset_out(o_coproc_reset_out),
		.i_start(m_start), .i_tag(m_tag), .i_offer(m_offer), .i_rogue(m_rogue),
		.o_coproc_quiescent(i_coproc_quiescent),
		.o_cop_xact_valid(i_cop_xact_valid), .o_cop_xact_tag(i_cop_xact_tag));
	// Free-running core clock, 4 ns period.
	always #2 i_core_clk = ~i_core_clk;
	// Compares one value and reports a mismatch.
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			$display("BAD %s expected %h seen %h", n, e, g);
			failures++;
		end
	endtask
	// Prints the verdict and ends the run.
	task finish_test;
		if (failures == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Bounded wait for reset output (sel 0) or sleep (sel 1) to reach v.
	task wt(input bit sel, input logic v);
		for (int i = 0; i < 24; i++)
		begin
			@(posedge i_core_clk);
			#1;
			if ((sel ? o_sleep_active : o_coproc_reset_out) === v)
				return;
		end
		chk(sel ? "sleep wait" : "reset wait", v, ~v);
		finish_test();
	endtask
	// Expected kill type: commit reads 00.
	function automatic logic [1:0] exp_type(input logic s, input logic e);
		return s ? {1'b1, e} : 2'h0;
	endfunction
	// One register access; a read returns its data.
	task reg_op(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= w;
		i_reg_rd <= !w;
		@(posedge i_core_clk);
		i_reg_wr <= 1'b0;
		i_reg_rd <= 1'b0;
		#1;
		rv = o_reg_rdata;
	endtask
	// Issue, then kill with a same-cycle transaction, then retry it.
	task kill_op(input logic [1:0] t, input logic s, input logic e);
		@(posedge i_core_clk);
		{i_issue_valid, i_issue_tag} <= {1'b1, t};
		@(posedge i_core_clk);
		i_issue_valid <= 1'b0;
		{i_kill_valid, i_kill_squash, i_coproc_exception_flag} <= {1'b1, s, e};
		{i_kill_tag, i_xact_valid, i_xact_tag} <= {t, 1'b1, t};
		@(posedge i_core_clk);
		i_kill_valid <= 1'b0;
		#1;
		chk("strobe", 1, o_kill_strobe);
		chk("type", exp_type(s, e), o_kill_type);
		chk("xact", !s, o_xact_issue);
		chk("xtag", t, o_xact_tag);
		@(posedge i_core_clk);
		i_xact_valid <= 1'b0;
		#1;
		chk("retry", !s, o_xact_issue);
		nk += s;
	endtask
	// Model offer one cycle later; accept shows after the next edge.
	task offer(input logic r, input logic exp);
		@(posedge i_core_clk);
		{m_offer, m_rogue} <= {1'b1, r};
		@(posedge i_core_clk);
		m_offer <= 1'b0;
		@(posedge i_core_clk);
		#1;
		chk("accept", exp, o_cop_xact_accept);
	endtask
	// Starts model work on a tag.
	task start(input logic [1:0] t);
		@(posedge i_core_clk);
		{m_start, m_tag} <= {1'b1, t};
		@(posedge i_core_clk);
		m_start <= 1'b0;
	endtask
	initial
	begin
		repeat (3) @(posedge i_core_clk);
		i_resetn <= 1'b1;
		@(posedge i_core_clk);
		#1;
		chk("rst out", 1, o_coproc_reset_out);
		wt(0, 0);
		for (int i = 0; i < 20; i++)
		begin
			sq = (i < 4) ? i[1] : $random(seed);
			ex = (i < 4) ? i[0] : $random(seed);
			kill_op(2'($random(seed)), sq, ex);
		end
		start(2'h1);
		kill_op(2'h1, 1'b1, 1'b0);
		offer(1'b1, 1'b0);
		start(2'h1);
		@(posedge i_core_clk);
		{i_issue_valid, i_issue_tag} <= {1'b1, 2'h1};
		@(posedge i_core_clk);
		i_issue_valid <= 1'b0;
		offer(1'b0, 1'b1);
		reg_op(1'b0, 8'h08, 32'h0);
		chk("killcnt", nk, rv);
		reg_op(1'b1, 8'h08, 32'h0);
		reg_op(1'b0, 8'h08, 32'h0);
		chk("cleared", 0, rv);
		reg_op(1'b0, 8'hFC, 32'h0);
		chk("unmapped", 0, rv);
		kill_op(2'h2, 1'b1, 1'b1);
		@(posedge i_core_clk);
		i_soft_reset <= 1'b1;
		@(posedge i_core_clk);
		i_soft_reset <= 1'b0;
		#1;
		chk("soft rst", 1, o_coproc_reset_out);
		reg_op(1'b0, 8'h04, 32'h0);
		chk("status rst", 32'hB, rv);
		wt(0, 0);
		reg_op(1'b1, 8'h00, 32'h3);
		wt(0, 1);
		wt(0, 0);
		reg_op(1'b0, 8'h04, 32'h0);
		chk("status", 32'h3, rv);
		// Read data stands one cycle only, then returns to zero.
		@(posedge i_core_clk);
		#1;
		chk("rdata idle", 0, o_reg_rdata);
		// Soft reset bit is write-only; sleep enable reads back.
		reg_op(1'b0, 8'h00, 32'h0);
		chk("ctrl", 32'h2, rv);
		// With sleep disabled an idle coprocessor must not let it sleep.
		reg_op(1'b1, 8'h00, 32'h0);
		@(posedge i_core_clk);
		i_sleep_req <= 1'b1;
		repeat (6) @(posedge i_core_clk);
		i_sleep_req <= 1'b0;
		#1;
		chk("sleep off", 0, o_sleep_active);
		reg_op(1'b1, 8'h00, 32'h2);
		start(2'h0);
		i_sleep_req <= 1'b1;
		repeat (8) @(posedge i_core_clk);
		#1;
		chk("busy sleep", 0, o_sleep_active);
		wt(1, 1);
		reg_op(1'b0, 8'h04, 32'h0);
		chk("status sleep", 32'h7, rv);
		@(posedge i_core_clk);
		i_sleep_req <= 1'b0;
		wt(1, 0);
		@(posedge i_core_clk);
		{i_resetn, i_coproc_attached_strap} <= 2'b00;
		repeat (3) @(posedge i_core_clk);
		i_resetn <= 1'b1;
		wt(0, 1);
		wt(0, 0);
		start(2'h3);
		i_sleep_req <= 1'b1;
		wt(1, 1);
		finish_test();
	end
endmodule
bind cpk_port cpk_port_monitor u_mon (.i_core_clk, .i_resetn, .i_soft_reset,
	.i_kill_valid, .i_kill_squash, .i_kill_tag, .i_coproc_exception_flag,
	.i_xact_valid, .i_xact_tag, .i_coproc_attached_strap, .i_coproc_quiescent,
	.o_kill_strobe, .o_kill_type, .o_xact_issue, .o_coproc_reset_out,
	.o_sleep_active);
